// >>> pkg/dea_pkg.sv
// Constants for the data memory access block: addresses, control bits and timing.
//
// Contract
// - Window enabled: far moves through the pointer reach EEPROM, addresses 000H..7FFH.
// - Window disabled: far moves go to off-chip data memory.
// - No EEPROM byte is written unless write enable is 1 at the move.
// - Write cycles time themselves, about 4 ms each.
// - Ready flag reads 0 while programming, 1 when a new write may start.
// - With page load-only set, an EEPROM write only fills the buffer.
// - Clearing load-only before the last write programs the whole buffered page at once.
// - A page cycle lasts as long as a byte cycle, about 4 ms.
// - Reads while programming return the written byte with MSB inverted.
// - 2K bytes of EEPROM, 256 bytes RAM; upper RAM separate from registers.
// - Direct access above 7FH reaches the register space.
// - Indirect access above 7FH reaches the upper 128 RAM bytes.
// - Stack pushes and pops count as indirect accesses.
// - Two 16-bit pointers, at 82H..83H and 84H..85H.
// - Pointer bank select 0 picks the first pointer, 1 the second.
// - Far moves at or above 2K always go to external memory.
// - Low supply aborts a running cycle and blocks new ones.

package dea_pkg;

    // ----------------------------------------------------------------
    // Register space addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] DEA_ADDR_DP0L   = 8'h82;
    localparam logic [7:0] DEA_ADDR_DP0H   = 8'h83;
    localparam logic [7:0] DEA_ADDR_DP1L   = 8'h84;
    localparam logic [7:0] DEA_ADDR_DP1H   = 8'h85;
    localparam logic [7:0] DEA_ADDR_ECTL   = 8'h96;
    localparam logic [7:0] DEA_RAM_LOW_TOP = 8'h7F;

    // ----------------------------------------------------------------
    // Control register fields and reset value
    // ----------------------------------------------------------------
    localparam int         DEA_BIT_LOAD  = 5;
    localparam int         DEA_BIT_WEN   = 4;
    localparam int         DEA_BIT_WIN   = 3;
    localparam int         DEA_BIT_SEL   = 2;
    localparam int         DEA_BIT_RDY   = 1;
    localparam int         DEA_BIT_WBLK  = 0;
    localparam logic [7:0] DEA_ECTL_RST  = 8'h03;
    localparam logic [7:0] DEA_MSB_FLIP  = 8'h80;
    localparam logic [15:0] DEA_PTR_RST  = 16'h0000;

    // ----------------------------------------------------------------
    // Memory geometry
    // ----------------------------------------------------------------
    localparam int DEA_EE_AW    = 11;
    localparam int DEA_EE_BYTES = 2048;
    localparam int DEA_PG_AW    = 5;
    localparam int DEA_PG_BYTES = 32;
    localparam int DEA_RAM_BYTES = 256;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int DEA_CLK_PERIOD_NS = 4;
    localparam int DEA_PROG_TIME_NS  = 4000000;
    localparam int DEA_PROG_CYCLES   = DEA_PROG_TIME_NS / DEA_CLK_PERIOD_NS;

    typedef enum logic {DEA_PG_IDLE, DEA_PG_RUN} dea_pg_t;

endpackage

// >>> rtl/dea_top.sv
// Data memory access: internal RAM, pointers, control register and data EEPROM.
`timescale 1ns/1ps
`default_nettype none

module dea_top #(
    parameter int PROG_CYCLES = dea_pkg::DEA_PROG_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        IN_REQ,
    input  wire logic        IN_WE,
    input  wire logic        IN_INDIRECT,
    input  wire logic [7:0]  IN_ADDR,
    input  wire logic        FAR_REQ,
    input  wire logic        FAR_WE,
    input  wire logic [7:0]  WDATA,
    input  wire logic        SUPPLY_OK,
    input  wire logic        EXT_ACK,
    input  wire logic [7:0]  EXT_RDATA,
    output logic             DONE,
    output logic [7:0]       RDATA,
    output logic             EXT_REQ,
    output logic             EXT_WE,
    output logic [15:0]      EXT_ADDR,
    output logic [7:0]       EXT_WDATA
);

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    logic [7:0]  ram [dea_pkg::DEA_RAM_BYTES];
    logic [7:0]  col_rd [dea_pkg::DEA_PG_BYTES];
    logic [7:0]  pbuf [dea_pkg::DEA_PG_BYTES];
    logic [dea_pkg::DEA_PG_BYTES-1:0] pmask;
    logic [dea_pkg::DEA_EE_AW-dea_pkg::DEA_PG_AW-1:0] ppage;
    logic [15:0] dp0;
    logic [15:0] dp1;
    logic        load_only;
    logic        wr_en;
    logic        win_en;
    logic        bank_sel;
    logic        sup_s1;
    logic        sup_s2;
    logic        ext_pend;
    logic        ext_rd;
    logic [7:0]  last_byte;
    logic [19:0] pcnt;
    dea_pkg::dea_pg_t pstate;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    logic        sfr_hit;
    logic        in_take;
    logic        far_take;
    logic [15:0] far_addr;
    logic        far_ee;
    logic        ee_wr;
    logic        ee_busy;
    logic        prog_fin;
    logic [7:0]  ectl_val;
    logic [7:0]  sfr_rd;
    logic [dea_pkg::DEA_PG_AW-1:0] widx;
    logic [dea_pkg::DEA_EE_AW-dea_pkg::DEA_PG_AW-1:0] wpage;

    // Direct access above the low half means register space; indirect never does
    assign sfr_hit  = !IN_INDIRECT && (IN_ADDR > dea_pkg::DEA_RAM_LOW_TOP);
    // New requests wait while an external transfer is outstanding
    assign in_take  = IN_REQ && !ext_pend;
    assign far_take = FAR_REQ && !IN_REQ && !ext_pend;
    assign far_addr = bank_sel ? dp1 : dp0;
    // Only the low 2K sits behind the window, the rest stays external
    assign far_ee   = win_en && (far_addr[15:dea_pkg::DEA_EE_AW] == '0);
    assign ee_busy  = (pstate == dea_pkg::DEA_PG_RUN);
    // Write needs enable, an idle array and a healthy supply
    assign ee_wr    = far_take && far_ee && FAR_WE && wr_en && !ee_busy && sup_s2;
    assign prog_fin = ee_busy && sup_s2 && (pcnt == 20'(PROG_CYCLES - 1));
    assign widx     = far_addr[dea_pkg::DEA_PG_AW-1:0];
    assign wpage    = far_addr[dea_pkg::DEA_EE_AW-1:dea_pkg::DEA_PG_AW];

    // Control register image; upper two bits read zero
    always_comb
    begin
        ectl_val                       = 8'h00;
        ectl_val[dea_pkg::DEA_BIT_LOAD] = load_only;
        ectl_val[dea_pkg::DEA_BIT_WEN]  = wr_en;
        ectl_val[dea_pkg::DEA_BIT_WIN]  = win_en;
        ectl_val[dea_pkg::DEA_BIT_SEL]  = bank_sel;
        ectl_val[dea_pkg::DEA_BIT_RDY]  = !ee_busy;
        ectl_val[dea_pkg::DEA_BIT_WBLK] = sup_s2;
    end

    // Register space read mux; registers owned elsewhere read zero here
    always_comb
    begin
        case (IN_ADDR)
            dea_pkg::DEA_ADDR_DP0L: sfr_rd = dp0[7:0];
            dea_pkg::DEA_ADDR_DP0H: sfr_rd = dp0[15:8];
            dea_pkg::DEA_ADDR_DP1L: sfr_rd = dp1[7:0];
            dea_pkg::DEA_ADDR_DP1H: sfr_rd = dp1[15:8];
            dea_pkg::DEA_ADDR_ECTL: sfr_rd = ectl_val;
            default:                sfr_rd = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Supply monitor synchroniser
    // ----------------------------------------------------------------
    // Analog comparator is asynchronous; starts high to match reset image
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            sup_s1 <= 1'b1;
            sup_s2 <= 1'b1;
        end
        else
        begin
            sup_s1 <= SUPPLY_OK;
            sup_s2 <= sup_s1;
        end
    end

    // ----------------------------------------------------------------
    // Internal RAM, 256 bytes, upper half apart from register space
    // ----------------------------------------------------------------
    // No reset: contents are undefined at power-up like any RAM
    always_ff @(posedge REF_CLK)
    begin
        if (in_take && IN_WE && !sfr_hit)
        begin
            ram[IN_ADDR] <= WDATA;
        end
    end

    // ----------------------------------------------------------------
    // Data pointers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            dp0 <= dea_pkg::DEA_PTR_RST;
            dp1 <= dea_pkg::DEA_PTR_RST;
        end
        else if (in_take && IN_WE && sfr_hit)
        begin
            case (IN_ADDR)
                dea_pkg::DEA_ADDR_DP0L: dp0[7:0]  <= WDATA;
                dea_pkg::DEA_ADDR_DP0H: dp0[15:8] <= WDATA;
                dea_pkg::DEA_ADDR_DP1L: dp1[7:0]  <= WDATA;
                dea_pkg::DEA_ADDR_DP1H: dp1[15:8] <= WDATA;
                default:                dp0       <= dp0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Control register writable bits
    // ----------------------------------------------------------------
    // Ready and supply bits are status only; writes to them are dropped
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            load_only <= dea_pkg::DEA_ECTL_RST[dea_pkg::DEA_BIT_LOAD];
            wr_en     <= dea_pkg::DEA_ECTL_RST[dea_pkg::DEA_BIT_WEN];
            win_en    <= dea_pkg::DEA_ECTL_RST[dea_pkg::DEA_BIT_WIN];
            bank_sel  <= dea_pkg::DEA_ECTL_RST[dea_pkg::DEA_BIT_SEL];
        end
        else if (in_take && IN_WE && sfr_hit && (IN_ADDR == dea_pkg::DEA_ADDR_ECTL))
        begin
            load_only <= WDATA[dea_pkg::DEA_BIT_LOAD];
            wr_en     <= WDATA[dea_pkg::DEA_BIT_WEN];
            win_en    <= WDATA[dea_pkg::DEA_BIT_WIN];
            bank_sel  <= WDATA[dea_pkg::DEA_BIT_SEL];
        end
    end

    // ----------------------------------------------------------------
    // Page write buffer
    // ----------------------------------------------------------------
    // Data lanes have no reset; the valid mask alone marks pending bytes
    always_ff @(posedge REF_CLK)
    begin
        if (ee_wr)
        begin
            pbuf[widx] <= WDATA;
        end
    end

    // A load into another page drops bytes of the old page
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pmask <= '0;
            ppage <= '0;
        end
        else if (ee_wr)
        begin
            if (pmask == '0 || wpage == ppage)
            begin
                pmask[widx] <= 1'b1;
            end
            else
            begin
                pmask       <= '0;
                pmask[widx] <= 1'b1;
            end
            ppage <= wpage;
        end
        else if (prog_fin || (ee_busy && !sup_s2))
        begin
            pmask <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Programming sequencer
    // ----------------------------------------------------------------
    // One timed cycle per commit, whether one byte or a full page
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pstate    <= dea_pkg::DEA_PG_IDLE;
            pcnt      <= '0;
            last_byte <= 8'h00;
        end
        else
        begin
            case (pstate)
                dea_pkg::DEA_PG_IDLE:
                begin
                    pcnt <= '0;
                    if (ee_wr && !load_only)
                    begin
                        pstate    <= dea_pkg::DEA_PG_RUN;
                        last_byte <= WDATA;
                    end
                end
                dea_pkg::DEA_PG_RUN:
                begin
                    if (!sup_s2 || prog_fin)
                    begin
                        pstate <= dea_pkg::DEA_PG_IDLE;
                    end
                    pcnt <= pcnt + 20'd1;
                end
                default:
                begin
                    pstate <= dea_pkg::DEA_PG_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // EEPROM array
    // ----------------------------------------------------------------
    // All marked bytes land together at the end of the cycle
    generate
        for (genvar gi = 0; gi < dea_pkg::DEA_PG_BYTES; gi++)
        begin : g_prog
            logic [7:0] col [dea_pkg::DEA_EE_BYTES / dea_pkg::DEA_PG_BYTES]; // One lane, one writer
            always_ff @(posedge REF_CLK)
            begin
                if (prog_fin && pmask[gi])
                begin
                    col[ppage] <= pbuf[gi];
                end
            end
            assign col_rd[gi] = col[wpage];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Answers to the core
    // ----------------------------------------------------------------
    // One answer per taken request; external ones wait for the bus
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            DONE  <= 1'b0;
            RDATA <= 8'h00;
        end
        else
        begin
            DONE <= 1'b0;
            if (in_take)
            begin
                DONE <= 1'b1;
                if (!IN_WE)
                begin
                    RDATA <= sfr_hit ? sfr_rd : ram[IN_ADDR];
                end
            end
            else if (far_take && far_ee)
            begin
                DONE <= 1'b1;
                if (!FAR_WE)
                begin
                    // Busy array shows the byte in flight, top bit flipped
                    RDATA <= ee_busy ? (last_byte ^ dea_pkg::DEA_MSB_FLIP)
                                     : col_rd[widx];
                end
            end
            else if (ext_pend && EXT_ACK)
            begin
                DONE <= 1'b1;
                if (ext_rd)
                begin
                    RDATA <= EXT_RDATA;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // External data memory port
    // ----------------------------------------------------------------
    // Request is a one-cycle pulse; address and data hold until the ack
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            EXT_REQ   <= 1'b0;
            EXT_WE    <= 1'b0;
            EXT_ADDR  <= 16'h0000;
            EXT_WDATA <= 8'h00;
            ext_pend  <= 1'b0;
            ext_rd    <= 1'b0;
        end
        else
        begin
            EXT_REQ <= 1'b0;
            if (far_take && !far_ee)
            begin
                EXT_REQ   <= 1'b1;
                EXT_WE    <= FAR_WE;
                EXT_ADDR  <= far_addr;
                EXT_WDATA <= WDATA;
                ext_pend  <= 1'b1;
                ext_rd    <= !FAR_WE;
            end
            else if (ext_pend && EXT_ACK)
            begin
                ext_pend <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// >>> verif/dea_ext_mem.sv
// Off-chip data memory model answering the block's external handshake.
`timescale 1ns/1ps
`default_nettype none

module dea_ext_mem (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        req,
    input  wire logic        we,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [3:0]  lat,
    output logic             ack,
    output logic [7:0]       rdata
);
    logic [7:0] mem [0:255];
    logic [3:0] cnt;
    logic       busy;

    // Answer after lat idle cycles; the data bus toggles while not acking,
    // so a stale byte can never pass for a fresh one
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy  <= 1'b0;
            cnt   <= 4'h0;
            ack   <= 1'b0;
            rdata <= 8'h00;
        end
        else
        begin
            ack   <= 1'b0;
            rdata <= ~rdata;
            if (req)
            begin
                busy <= 1'b1;
                cnt  <= lat;
            end
            else if (busy && cnt == 4'h0)
            begin
                busy  <= 1'b0;
                ack   <= 1'b1;
                rdata <= mem[addr[7:0]];
                if (we)
                    mem[addr[7:0]] <= wdata;
            end
            else if (busy)
                cnt <= cnt - 4'h1;
        end
    end
endmodule

`default_nettype wire

// >>> verif/dea_top_props.sv
// Port-level checker for the data memory access block.
`timescale 1ns/1ps
`default_nettype none

module dea_top_chk (
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    input  wire logic        IN_REQ,
    input  wire logic        IN_WE,
    input  wire logic        IN_INDIRECT,
    input  wire logic [7:0]  IN_ADDR,
    input  wire logic        FAR_REQ,
    input  wire logic        FAR_WE,
    input  wire logic [7:0]  WDATA,
    input  wire logic        EXT_ACK,
    input  wire logic [7:0]  EXT_RDATA,
    input  wire logic        DONE,
    input  wire logic [7:0]  RDATA,
    input  wire logic        EXT_REQ,
    input  wire logic        EXT_WE,
    input  wire logic [15:0] EXT_ADDR,
    input  wire logic [7:0]  EXT_WDATA
);
    // ------------------------------------------------------------
    // Shadow of pointers and control bits seen through the ports
    // ------------------------------------------------------------
    logic        busy;
    logic [15:0] dp0, dp1;
    logic [3:0]  ctl;
    logic [7:0]  exp, msk;
    wire         take_in  = IN_REQ && !busy;
    wire         take_far = FAR_REQ && !IN_REQ && !busy;
    wire  [15:0] ptr      = ctl[0] ? dp1 : dp0;
    wire         ext_rt   = !ctl[1] || (ptr[15:11] != 5'h00);
    wire         wr_sfr   = take_in && IN_WE && !IN_INDIRECT;
    wire         sfr_rd   = take_in && !IN_WE && !IN_INDIRECT && IN_ADDR[7];

    // Pending external transfer, and register writes mirrored here
    always_ff @(posedge REF_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            busy <= 1'b0;
            dp0  <= 16'h0000;
            dp1  <= 16'h0000;
            ctl  <= 4'h0;
        end
        else
        begin
            if (take_far && ext_rt)
                busy <= 1'b1;
            else if (EXT_ACK)
                busy <= 1'b0;
            if (wr_sfr && IN_ADDR == 8'h82) dp0[7:0]  <= WDATA;
            if (wr_sfr && IN_ADDR == 8'h83) dp0[15:8] <= WDATA;
            if (wr_sfr && IN_ADDR == 8'h84) dp1[7:0]  <= WDATA;
            if (wr_sfr && IN_ADDR == 8'h85) dp1[15:8] <= WDATA;
            if (wr_sfr && IN_ADDR == 8'h96) ctl       <= WDATA[5:2];
        end
    end

    // Expected register read; status bits are masked off, they live in the design
    always_comb
    begin
        msk = 8'hFF;
        case (IN_ADDR)
            8'h82:   exp = dp0[7:0];
            8'h83:   exp = dp0[15:8];
            8'h84:   exp = dp1[7:0];
            8'h85:   exp = dp1[15:8];
            8'h96:   begin exp = {2'b00, ctl, 2'b00}; msk = 8'hFC; end
            default: exp = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence s_far_ext;
        take_far && ext_rt;
    endsequence
    sequence s_ext_issue;
        EXT_REQ && !DONE && EXT_ADDR == $past(ptr) && EXT_WE == $past(FAR_WE)
            && (!EXT_WE || EXT_WDATA == $past(WDATA));
    endsequence

    property p_ext_route;  s_far_ext |=> s_ext_issue; endproperty
    property p_win_route;  take_far && !ext_rt |=> DONE && !EXT_REQ; endproperty
    property p_int_done;   take_in |=> DONE && !EXT_REQ; endproperty
    property p_ext_done;   busy && EXT_ACK |=> DONE ##1 !DONE; endproperty
    property p_quiet;      busy && !EXT_ACK |=> !DONE; endproperty
    property p_ext_pulse;  EXT_REQ |=> !EXT_REQ; endproperty
    property p_ext_hold;   busy && !EXT_REQ |=> $stable(EXT_ADDR) && $stable(EXT_WE); endproperty
    property p_ext_rd;     busy && EXT_ACK && !EXT_WE |=> RDATA == $past(EXT_RDATA); endproperty
    property p_sfr_rd;     sfr_rd |=> (RDATA & $past(msk)) == $past(exp); endproperty

    a_ext_route: assert property (p_ext_route) else $error("far move not sent outside");
    a_win_route: assert property (p_win_route) else $error("window move went outside");
    a_int_done:  assert property (p_int_done) else $error("internal access not done");
    a_ext_done:  assert property (p_ext_done) else $error("external done missing");
    a_quiet:     assert property (p_quiet) else $error("done while external pending");
    a_ext_pulse: assert property (p_ext_pulse) else $error("external request too long");
    a_ext_hold:  assert property (p_ext_hold) else $error("external address moved");
    a_ext_rd:    assert property (p_ext_rd) else $error("external read data lost");
    a_sfr_rd:    assert property (p_sfr_rd) else $error("register read wrong");
endmodule

bind dea_top dea_top_chk u_chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .IN_REQ(IN_REQ), .IN_WE(IN_WE),
    .IN_INDIRECT(IN_INDIRECT), .IN_ADDR(IN_ADDR), .FAR_REQ(FAR_REQ), .FAR_WE(FAR_WE), .WDATA(WDATA),
    .EXT_ACK(EXT_ACK), .EXT_RDATA(EXT_RDATA), .DONE(DONE), .RDATA(RDATA), .EXT_REQ(EXT_REQ),
    .EXT_WE(EXT_WE), .EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA));

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the data memory access block.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam int PROG = 20;
    logic        ref_clk, rstn, in_req, in_we, in_ind, far_req, far_we, supply_ok;
    logic        ext_ack, done, ext_req, ext_we;
    logic [7:0]  in_addr, wdata, ext_rdata, rdata, ext_wdata, q;
    logic [15:0] ext_addr;
    logic [3:0]  lat;
    int          fail_count, cmp_count, ext_n, n0;

    dea_top #(.PROG_CYCLES(PROG)) u_dea_top (.REF_CLK(ref_clk), .RSTN(rstn), .IN_REQ(in_req), .IN_WE(in_we),
        .IN_INDIRECT(in_ind), .IN_ADDR(in_addr), .FAR_REQ(far_req), .FAR_WE(far_we), .WDATA(wdata),
        .SUPPLY_OK(supply_ok), .EXT_ACK(ext_ack), .EXT_RDATA(ext_rdata), .DONE(done), .RDATA(rdata),
        .EXT_REQ(ext_req), .EXT_WE(ext_we), .EXT_ADDR(ext_addr), .EXT_WDATA(ext_wdata));
    dea_ext_mem u_dea_ext_mem (.clk(ref_clk), .rstn(rstn), .req(ext_req), .we(ext_we), .addr(ext_addr),
        .wdata(ext_wdata), .lat(lat), .ack(ext_ack), .rdata(ext_rdata));

    // ------------------------------------------------------------
    // Clock, external request counter and watchdog
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) if (ext_req === 1'b1) ext_n++;

    // Whole run is a few hundred cycles; this bound only cuts a hang
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, e, g);
        end
    endtask

    // One request raised at a falling edge, held over the taking edge, then wait for done
    task automatic acc(input logic far, input logic we, input logic ind, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        @(negedge ref_clk);
        far_req = far;
        in_req  = !far;
        far_we  = we;
        in_we   = we;
        in_ind  = ind;
        in_addr = a;
        wdata   = d;
        @(negedge ref_clk);
        far_req = 1'b0;
        in_req  = 1'b0;
        while (done !== 1'b1 && n < 50)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("done", 16'h1, {15'h0, done});
        r = rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b0, 1'b1, 1'b0, a, d, q);
    endtask

    task automatic rchk(input logic far, input logic ind, input logic [7:0] a, input logic [7:0] e,
                        input string name);
        acc(far, 1'b0, ind, a, 8'h00, q);
        chk(name, {8'h00, e}, {8'h00, q});
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        {rstn, in_req, in_we, in_ind, far_req, far_we, in_addr, wdata, lat} = '0;
        supply_ok = 1'b1;
        repeat (6) @(negedge ref_clk);
        rstn = 1'b1;
        rchk(0, 0, 8'h96, 8'h03, "ctl reset");
        rchk(0, 0, 8'h84, 8'h00, "ptr reset");
        acc(0, 1, 1, 8'hA0, 8'h5C, q);
        wr(8'hA0, 8'hC3);
        rchk(0, 0, 8'hA0, 8'h00, "sfr A0");
        rchk(0, 1, 8'hA0, 8'h5C, "ram A0");
        acc(0, 1, 1, 8'h85, 8'h99, q);
        rchk(0, 0, 8'h85, 8'h00, "ptr hi");
        wr(8'h82, 8'h23);
        wr(8'h83, 8'h01);
        wr(8'h84, 8'h56);
        wr(8'h85, 8'h04);
        rchk(0, 0, 8'h83, 8'h01, "dp0 hi");
        // Window off: moves reach the partner, pointer picked by bank select
        acc(1, 1, 0, 8'h00, 8'h5A, q);
        chk("ext addr0", 16'h0123, ext_addr);
        wr(8'h96, 8'h04);
        lat = 4'h3;
        acc(1, 1, 0, 8'h00, 8'hA5, q);
        chk("ext addr1", 16'h0456, ext_addr);
        rchk(1, 0, 8'h00, 8'hA5, "ext rd1");
        // Window on but pointer at 2K goes outside
        wr(8'h83, 8'h08);
        wr(8'h96, 8'h08);
        rchk(1, 0, 8'h00, 8'h5A, "ext rd 2K");
        chk("ext addr 2K", 16'h0823, ext_addr);
        // Byte write into the window via second pointer
        wr(8'h96, 8'h1C);
        n0 = ext_n;
        acc(1, 1, 0, 8'h00, 8'h3C, q);
        rchk(0, 0, 8'h96, 8'h1D, "ready low");
        rchk(1, 0, 8'h00, 8'hBC, "busy read");
        repeat (PROG - 10) @(negedge ref_clk);
        rchk(0, 0, 8'h96, 8'h1D, "still busy");
        repeat (12) @(negedge ref_clk);
        rchk(0, 0, 8'h96, 8'h1F, "ready high");
        rchk(1, 0, 8'h00, 8'h3C, "ee data");
        chk("no ext", n0[15:0], ext_n[15:0]);
        // Write enable clear, then low supply: writes dropped
        wr(8'h96, 8'h0C);
        acc(1, 1, 0, 8'h00, 8'h77, q);
        rchk(0, 0, 8'h96, 8'h0F, "no cycle");
        wr(8'h96, 8'h1C);
        supply_ok = 1'b0;
        repeat (4) @(negedge ref_clk);
        acc(1, 1, 0, 8'h00, 8'h66, q);
        rchk(0, 0, 8'h96, 8'h1E, "low supply");
        rchk(1, 0, 8'h00, 8'h3C, "kept data");
        supply_ok = 1'b1;
        repeat (4) @(negedge ref_clk);
        // Supply drop in mid-cycle aborts it and keeps the old byte
        acc(1, 1, 0, 8'h00, 8'h55, q);
        supply_ok = 1'b0;
        repeat (4) @(negedge ref_clk);
        rchk(0, 0, 8'h96, 8'h1E, "abort");
        supply_ok = 1'b1;
        repeat (4) @(negedge ref_clk);
        rchk(1, 0, 8'h00, 8'h3C, "aborted data");
        // Page load then commit
        wr(8'h96, 8'h3C);
        for (int i = 0; i < 3; i++)
        begin
            if (i == 2) wr(8'h96, 8'h1C);
            wr(8'h84, 8'h40 + i[7:0]);
            wr(8'h85, 8'h00);
            acc(1, 1, 0, 8'h00, 8'h11 * (i[7:0] + 8'h1), q);
            if (i == 1) rchk(0, 0, 8'h96, 8'h3F, "load only");
        end
        repeat (PROG - 6) @(negedge ref_clk);
        rchk(0, 0, 8'h96, 8'h1D, "page busy");
        repeat (12) @(negedge ref_clk);
        rchk(0, 0, 8'h96, 8'h1F, "page done");
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h84, 8'h40 + i[7:0]);
            rchk(1, 0, 8'h00, 8'h11 * (i[7:0] + 8'h1), "page byte");
        end
        wr(8'h84, 8'h56);
        wr(8'h85, 8'h04);
        rchk(1, 0, 8'h00, 8'h3C, "other byte");
        summarize();
    end
endmodule

`default_nettype wire
